// [src/rdio_port.sv]
// Purpose: Dedicated external signal port of a robot controller, APB side
// Assumes: Pin inputs asynchronous to pclk, sequencer holds levels
// Notes:   Functional notes below; configuration via APB registers
//
// Functional notes
// - Numeric groups carry program, line, override, error values
// - Numeric fields set by four five-bit limits
// - Program request presents number, raises acknowledge
// - Line request presents line number, raises acknowledge
// - Override request presents override, raises acknowledge
// - Error request presents error number, raises acknowledge
// - Jog enable validates jog, status reports it
// - Two-bit jog mode echoed on status
// - Eight positive jog inputs request motion
// - Eight negative jog inputs request motion
// - Five hand faults mirrored while held
// - Five air faults mirrored while held
// - User region outputs high inside region
// - Region outputs use consecutive bit range
// - Level signals act only while on
// - Either opened stop channel forces stop
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module rdio_port (
   input  wire  logic               pclk,
   input  wire  logic               presetn,
   input  wire  logic               psel,
   input  wire  logic               penable,
   input  wire  logic               pwrite,
   input  wire  logic [7:0]         paddr,
   input  wire  logic [31:0]        pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire  rdio_pkg::rdio_pins_s pins_in,
   output rdio_pkg::rdio_out_s      pins_out,
   output logic                     irq
);
   import rdio_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   rdio_pins_s   pins_s1_ff;
   rdio_pins_s   pins_s2_ff;
   rdio_pins_s   pins_d_ff;
   rdio_out_s    out_ff;
   rdio_src_e    src_ff;
   rdio_src_e    nxt_src;
   rdio_status_s status;
   logic [31:0]  ctrl_ff;
   logic [31:0]  num_cfg_ff;
   logic [31:0]  area_cfg_ff;
   logic [31:0]  prog_ff;
   logic [31:0]  line_ff;
   logic [31:0]  ovrd_ff;
   logic [31:0]  err_ff;
   logic [7:0]   region_ff;
   logic [31:0]  prdata_ff;
   logic         pready_ff;
   logic         pslverr_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] nxt_irq_stat;
   logic [IRQ_W-1:0] nxt_irq_mask;
   logic [IRQ_W-1:0] irq_event;
   logic         irq_ff;
   logic         nxt_jog_valid;
   logic         estop_now;
   logic         rise_prog;
   logic         rise_line;
   logic         rise_ovrd;
   logic         rise_err;
   logic         rise_jog;
   logic         apb_req;
   logic         apb_cap;
   logic         apb_done;
   logic         apb_wr;
   logic [31:0]  rd_data;
   logic         rd_hit;
   logic [31:0]  num_value;
   logic [31:0]  nxt_gp_out;
   logic [4:0]   in_lo;
   logic [4:0]   in_hi;
   logic [4:0]   out_lo;
   logic [4:0]   out_hi;
   logic [4:0]   area_lo;
   logic [4:0]   area_hi;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Third stage feeds only the edge detectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_s1_ff <= '0;
         pins_s2_ff <= '0;
         pins_d_ff  <= '0;
         // Stop contacts idle closed, so no false trip follows reset
         pins_s1_ff.estop_a_closed <= 1'b1;
         pins_s1_ff.estop_b_closed <= 1'b1;
         pins_s2_ff.estop_a_closed <= 1'b1;
         pins_s2_ff.estop_b_closed <= 1'b1;
         pins_d_ff.estop_a_closed  <= 1'b1;
         pins_d_ff.estop_b_closed  <= 1'b1;
      end else begin
         pins_s1_ff <= pins_in;
         pins_s2_ff <= pins_s1_ff;
         pins_d_ff  <= pins_s2_ff;
      end
   end

   assign rise_prog = pins_s2_ff.prog_req & ~pins_d_ff.prog_req;
   assign rise_line = pins_s2_ff.line_req & ~pins_d_ff.line_req;
   assign rise_ovrd = pins_s2_ff.ovrd_req & ~pins_d_ff.ovrd_req;
   assign rise_err  = pins_s2_ff.err_req & ~pins_d_ff.err_req;
   assign rise_jog  = pins_s2_ff.jog_enable & ~pins_d_ff.jog_enable;

   // ----------------------------------------
   // Field limits
   // ----------------------------------------
   // four-element numeric field
   assign in_lo   = num_cfg_ff[CFG_IN_START +: CFG_POS_W];
   assign in_hi   = num_cfg_ff[CFG_IN_END +: CFG_POS_W];
   assign out_lo  = num_cfg_ff[CFG_OUT_START +: CFG_POS_W];
   assign out_hi  = num_cfg_ff[CFG_OUT_END +: CFG_POS_W];
   assign area_lo = area_cfg_ff[CFG_IN_START +: CFG_POS_W];
   assign area_hi = area_cfg_ff[CFG_IN_END +: CFG_POS_W];

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state: data captured first, pready shown next cycle
   // Read data latched on capture, so prdata stands with pready
   assign apb_req  = psel & penable;
   assign apb_cap  = apb_req & ~pready_ff;
   assign apb_done = apb_req & pready_ff;
   assign apb_wr   = apb_done & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff <= apb_cap;
         if (apb_cap) begin
            pslverr_ff <= ~rd_hit;
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
         end else if (apb_done) begin
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Unmapped offsets fall through, pslverr flags them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff     <= CTRL_RST;
         num_cfg_ff  <= NUM_CFG_RST;
         area_cfg_ff <= AREA_CFG_RST;
         prog_ff     <= VALUE_RST;
         line_ff     <= VALUE_RST;
         ovrd_ff     <= VALUE_RST;
         err_ff      <= VALUE_RST;
         region_ff   <= 8'h00;
         irq_mask_ff <= '0;
      end else if (apb_wr) begin
         unique case (paddr)
            OFS_CTRL:     ctrl_ff     <= pwdata;
            OFS_NUM_CFG:  num_cfg_ff  <= pwdata;
            OFS_AREA_CFG: area_cfg_ff <= pwdata;
            OFS_PROG:     prog_ff     <= pwdata;
            OFS_LINE:     line_ff     <= pwdata;
            OFS_OVRD:     ovrd_ff     <= pwdata;
            OFS_ERR:      err_ff      <= pwdata;
            OFS_REGION:   region_ff   <= pwdata[7:0];
            OFS_IRQ_MASK: irq_mask_ff <= pwdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_comb begin
      status = '{air_fault:    out_ff.air_fault,
                 hand_fault:   out_ff.hand_fault,
                 source:       src_ff,
                 jog_mode:     out_ff.jog_mode,
                 jog_valid:    out_ff.jog_valid,
                 estop_active: out_ff.estop_active};
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL:     rd_data = ctrl_ff;
         OFS_NUM_CFG:  rd_data = num_cfg_ff;
         OFS_AREA_CFG: rd_data = area_cfg_ff;
         OFS_PROG:     rd_data = prog_ff;
         OFS_LINE:     rd_data = line_ff;
         OFS_OVRD:     rd_data = ovrd_ff;
         OFS_ERR:      rd_data = err_ff;
         OFS_REGION:   rd_data = {24'h00_0000, region_ff};
         OFS_NUM_IN:   rd_data = rdio_get(pins_s2_ff.gp_in, in_lo, in_hi);
         OFS_STATUS:   rd_data = 32'(status);
         OFS_IRQ_STAT: rd_data = 32'(irq_stat_ff);
         OFS_IRQ_MASK: rd_data = 32'(irq_mask_ff);
         default:      rd_hit  = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Numeric output source
   // ----------------------------------------
   always_comb begin
      nxt_src = src_ff;
      unique case (src_ff)
         SRC_IDLE: begin
         end
         SRC_PROG: if (!pins_s2_ff.prog_req) nxt_src = SRC_IDLE;
         SRC_LINE: if (!pins_s2_ff.line_req) nxt_src = SRC_IDLE;
         SRC_OVRD: if (!pins_s2_ff.ovrd_req) nxt_src = SRC_IDLE;
         SRC_ERR:  if (!pins_s2_ff.err_req) nxt_src = SRC_IDLE;
         default:  nxt_src = SRC_IDLE;
      endcase
      // A request that loses to a newer one is not resumed
      // newest request wins, fixed priority
      if (rise_prog) begin
         nxt_src = SRC_PROG;
      end else if (rise_line) begin
         nxt_src = SRC_LINE;
      end else if (rise_ovrd) begin
         nxt_src = SRC_OVRD;
      end else if (rise_err) begin
         nxt_src = SRC_ERR;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_ff <= SRC_IDLE;
      end else begin
         src_ff <= nxt_src;
      end
   end

   always_comb begin
      num_value = 32'h0000_0000;
      unique case (nxt_src)
         SRC_PROG: num_value = prog_ff;
         SRC_LINE: num_value = line_ff;
         SRC_OVRD: num_value = ovrd_ff;
         SRC_ERR:  num_value = err_ff;
         default:  num_value = 32'h0000_0000;
      endcase
      // Overlapping fields OR together, software keeps them apart
      // region flags on their field
      nxt_gp_out = rdio_put(num_value, out_lo, out_hi)
                 | rdio_put({24'h00_0000, region_ff}, area_lo, area_hi);
   end

   // ----------------------------------------
   // Jog, faults and emergency stop
   // ----------------------------------------
   // Redundant contacts: one open channel is enough
   // normally closed, either channel trips
   assign estop_now = ~pins_s2_ff.estop_a_closed
                    | ~pins_s2_ff.estop_b_closed;

   always_comb begin
      nxt_jog_valid = out_ff.jog_valid;
      // Allow checked every cycle, so clearing it stops jog at once
      // armed on edge, dropped on release
      if (estop_now || !ctrl_ff[CTRL_JOG_ALLOW] || !pins_s2_ff.jog_enable) begin
         nxt_jog_valid = 1'b0;
      end else if (rise_jog) begin
         nxt_jog_valid = 1'b1;
      end
   end

   // ----------------------------------------
   // Registered pin outputs
   // ----------------------------------------
   // One shared flop stage keeps every pin path equally late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ff <= '0;
      end else begin
         out_ff.gp_out       <= nxt_gp_out;
         out_ff.prog_ack     <= (nxt_src == SRC_PROG);
         out_ff.line_ack     <= (nxt_src == SRC_LINE);
         out_ff.ovrd_ack     <= (nxt_src == SRC_OVRD);
         out_ff.err_ack      <= (nxt_src == SRC_ERR);
         out_ff.jog_valid    <= nxt_jog_valid;
         out_ff.jog_mode     <= pins_s2_ff.jog_mode;
         out_ff.jog_pos      <= nxt_jog_valid ? (pins_s2_ff.jog_pos & ~pins_s2_ff.jog_neg)
                                              : 8'h00;
         out_ff.jog_neg      <= nxt_jog_valid ? (pins_s2_ff.jog_neg & ~pins_s2_ff.jog_pos)
                                              : 8'h00;
         out_ff.hand_fault   <= pins_s2_ff.hand_fault;
         out_ff.air_fault    <= pins_s2_ff.air_fault;
         out_ff.estop_active <= estop_now;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   always_comb begin
      irq_event             = '0;
      irq_event[IRQ_ESTOP]  = estop_now & ~out_ff.estop_active;
      irq_event[IRQ_HAND]   = |(pins_s2_ff.hand_fault & ~pins_d_ff.hand_fault);
      irq_event[IRQ_AIR]    = |(pins_s2_ff.air_fault & ~pins_d_ff.air_fault);
      irq_event[IRQ_NUMREQ] = rise_prog | rise_line | rise_ovrd | rise_err;
      irq_event[IRQ_JOG]    = nxt_jog_valid & ~out_ff.jog_valid;
      nxt_irq_stat = irq_stat_ff;
      // Clear only bits that were returned, so late events survive
      if (apb_done && !pwrite && paddr == OFS_IRQ_STAT) begin
         nxt_irq_stat = irq_stat_ff & ~prdata_ff[IRQ_W-1:0];
      end
      nxt_irq_stat = nxt_irq_stat | irq_event;
      // New mask counts at once, so irq never lags a mask write
      nxt_irq_mask = irq_mask_ff;
      if (apb_wr && paddr == OFS_IRQ_MASK) begin
         nxt_irq_mask = pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= '0;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff      <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Plain wires only, each output is a flop above
   assign prdata   = prdata_ff;
   assign pready   = pready_ff;
   assign pslverr  = pslverr_ff;
   assign pins_out = out_ff;
   assign irq      = irq_ff;

endmodule : rdio_port

`default_nettype wire

// [src/rdio_pkg.sv]
// Purpose: Shared constants, types and field helpers for the dedicated I/O port
// Assumes: APB3 slave, 32-bit data, byte addresses in 8 bits
// Notes:   Configuration words pack bit-range limits of the pin fields
package rdio_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_NUM_CFG  = 8'h04;
   localparam logic [7:0] OFS_AREA_CFG = 8'h08;
   localparam logic [7:0] OFS_PROG     = 8'h0C;
   localparam logic [7:0] OFS_LINE     = 8'h10;
   localparam logic [7:0] OFS_OVRD     = 8'h14;
   localparam logic [7:0] OFS_ERR      = 8'h18;
   localparam logic [7:0] OFS_REGION   = 8'h1C;
   localparam logic [7:0] OFS_NUM_IN   = 8'h20;
   localparam logic [7:0] OFS_STATUS   = 8'h24;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned CTRL_JOG_ALLOW = 0;
   localparam int unsigned CFG_IN_START   = 0;
   localparam int unsigned CFG_IN_END     = 8;
   localparam int unsigned CFG_OUT_START  = 16;
   localparam int unsigned CFG_OUT_END    = 24;
   localparam int unsigned CFG_POS_W      = 5;
   localparam int unsigned IRQ_ESTOP      = 0;
   localparam int unsigned IRQ_HAND       = 1;
   localparam int unsigned IRQ_AIR        = 2;
   localparam int unsigned IRQ_NUMREQ     = 3;
   localparam int unsigned IRQ_JOG        = 4;
   localparam int unsigned IRQ_W          = 5;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] NUM_CFG_RST  = 32'h0F00_0F00;
   localparam logic [31:0] AREA_CFG_RST = 32'h0000_1710;
   localparam logic [31:0] VALUE_RST    = 32'h0000_0000;

   typedef enum logic [2:0] {
      SRC_IDLE = 3'h0,
      SRC_PROG = 3'h1,
      SRC_LINE = 3'h3,
      SRC_OVRD = 3'h2,
      SRC_ERR  = 3'h6
   } rdio_src_e;

   typedef struct packed {
      logic [31:0] gp_in;
      logic        prog_req;
      logic        line_req;
      logic        ovrd_req;
      logic        err_req;
      logic        jog_enable;
      logic [1:0]  jog_mode;
      logic [7:0]  jog_pos;
      logic [7:0]  jog_neg;
      logic [4:0]  hand_fault;
      logic [4:0]  air_fault;
      logic        estop_a_closed;
      logic        estop_b_closed;
   } rdio_pins_s;

   typedef struct packed {
      logic [31:0] gp_out;
      logic        prog_ack;
      logic        line_ack;
      logic        ovrd_ack;
      logic        err_ack;
      logic        jog_valid;
      logic [1:0]  jog_mode;
      logic [7:0]  jog_pos;
      logic [7:0]  jog_neg;
      logic [4:0]  hand_fault;
      logic [4:0]  air_fault;
      logic        estop_active;
   } rdio_out_s;

   typedef struct packed {
      logic [4:0] air_fault;
      logic [4:0] hand_fault;
      logic [2:0] source;
      logic [1:0] jog_mode;
      logic       jog_valid;
      logic       estop_active;
   } rdio_status_s;

   function automatic logic [31:0] rdio_mask(input logic [4:0] lo,
                                             input logic [4:0] hi);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         m[i] = (5'(i) >= lo) && (5'(i) <= hi);
      end
      return m;
   endfunction : rdio_mask

   function automatic logic [31:0] rdio_get(input logic [31:0] w,
                                            input logic [4:0]  lo,
                                            input logic [4:0]  hi);
      return (w & rdio_mask(lo, hi)) >> lo;
   endfunction : rdio_get

   function automatic logic [31:0] rdio_put(input logic [31:0] v,
                                            input logic [4:0]  lo,
                                            input logic [4:0]  hi);
      return (v << lo) & rdio_mask(lo, hi);
   endfunction : rdio_put

endpackage : rdio_pkg

// [bench/rdio_port_props.sv]
// Purpose: Port-level checks for the dedicated I/O port
// Assumes: Pin paths settle three edges after a change
// Notes:   Bound onto rdio_port, sees only its ports
`timescale 1ns/1ps
`default_nettype none

module rdio_port_props (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic [31:0]          prdata,
   input wire rdio_pkg::rdio_pins_s pins_in,
   input wire rdio_pkg::rdio_out_s  pins_out,
   input wire logic                 irq
);
   import rdio_pkg::*;
   logic [2:0] up_ff;
   logic       ok;

   // Synchronisers show reset values for a few edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) up_ff <= 3'h0;
      else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
   end
   assign ok = (up_ff >= 3'h4);

   // ---
   // Checks
   // ---
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ack_one_hot: assert property (
      $onehot0({pins_out.prog_ack, pins_out.line_ack, pins_out.ovrd_ack, pins_out.err_ack}))
      else $error("more than one acknowledge");
   a_hand_mirror: assert property (
      ok |-> pins_out.hand_fault == $past(pins_in.hand_fault, 3)) else $error("hand mirror");
   a_air_mirror: assert property (
      ok |-> pins_out.air_fault == $past(pins_in.air_fault, 3)) else $error("air mirror");
   a_stop_open: assert property (
      ok |-> pins_out.estop_active ==
         !($past(pins_in.estop_a_closed, 3) && $past(pins_in.estop_b_closed, 3)))
      else $error("stop channels");
   a_mode_echo: assert property (
      ok |-> pins_out.jog_mode == $past(pins_in.jog_mode, 3)) else $error("jog mode");
   a_prog_ack_rise: assert property (
      ok && $rose(pins_in.prog_req) && !pins_in.line_req && !pins_in.ovrd_req
         && !pins_in.err_req |-> ##[2:4] pins_out.prog_ack) else $error("prog ack late");
   a_ready_wait: assert property (
      psel && penable && !pready |=> pready) else $error("wait state");
   a_err_pair: assert property (
      pslverr |-> pready) else $error("slverr alone");
   a_rdata_idle: assert property (
      !pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
   a_jog_gated: assert property (
      !pins_out.jog_valid && !$past(pins_out.jog_valid) |->
         pins_out.jog_pos == 8'h00 && pins_out.jog_neg == 8'h00) else $error("jog gate");
endmodule : rdio_port_props

bind rdio_port rdio_port_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .pins_in(pins_in), .pins_out(pins_out), .irq(irq)
);

`default_nettype wire

// [bench/rdio_plc_model.sv]
// Purpose: Behavioural sequencer driving the dedicated pins
// Assumes: Bench states the wanted pin levels
// Notes:   Pins follow one edge later, like a scanned output card
`timescale 1ns/1ps
`default_nettype none

module rdio_plc_model (
   input  wire logic                 pclk,
   input  wire rdio_pkg::rdio_pins_s want,
   output rdio_pkg::rdio_pins_s      pins
);
   import rdio_pkg::*;
   always @(posedge pclk) begin
      pins <= want;
   end
endmodule : rdio_plc_model

`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the dedicated I/O port
// Assumes: 40 MHz pclk, APB master with bounded waits
// Notes:   Pin traffic passes through the sequencer model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import rdio_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  acks;
   rdio_pins_s  want, pins;
   rdio_out_s   pout;
   int          n_fail, n_tests;

   rdio_plc_model u_plc (.pclk(pclk), .want(want), .pins(pins));
   rdio_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins_in(pins), .pins_out(pout), .irq(irq));
   assign acks = {pout.prog_ack, pout.line_ack, pout.ovrd_ack, pout.err_ack};

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ---
   // Shared tasks
   // ---
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) chk("apb answer", 32'h0000_0000, 32'h0000_0001);
   endtask : apb

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   task automatic rq(input logic [3:0] r);
      {want.prog_req, want.line_req, want.ovrd_req, want.err_req} <= r;
   endtask : rq

   // ---
   // Scenarios
   // ---
   task automatic t_regs;
      apb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk("ctrl", q, CTRL_RST);
      apb(1'b0, OFS_NUM_CFG, 32'h0000_0000);
      chk("num_cfg", q, NUM_CFG_RST);
      apb(1'b0, OFS_AREA_CFG, 32'h0000_0000);
      chk("area_cfg", q, AREA_CFG_RST);
      apb(1'b0, 8'h30, 32'h0000_0000);
      chk("unmapped", {q[30:0], e}, 32'h0000_0001);
   endtask : t_regs

   task automatic t_num;
      logic [7:0]  ofs [4];
      rdio_src_e   src [4];
      logic [31:0] v;
      ofs = '{OFS_PROG, OFS_LINE, OFS_OVRD, OFS_ERR};
      src = '{SRC_PROG, SRC_LINE, SRC_OVRD, SRC_ERR};
      for (int i = 0; i < 4; i++) begin
         v = 32'h0012_3400 + 32'(i);
         apb(1'b1, ofs[i], v);
         rq(4'h8 >> i);
         wt(5);
         chk("ack", 32'(acks), 32'(4'h8 >> i));
         chk("num out", pout.gp_out, v & 32'h0000_FFFF);
         apb(1'b0, OFS_STATUS, 32'h0000_0000);
         chk("source", (q >> 4) & 32'h0000_0007, 32'(src[i]));
         rq(4'h0);
         wt(5);
         chk("ack off", 32'(acks), 32'h0000_0000);
      end
      rq(4'h8);
      wt(5);
      rq(4'hC);
      wt(5);
      chk("preempt", 32'(acks), 32'h0000_0004);
      chk("line out", pout.gp_out, 32'h0000_3401);
      rq(4'h0);
      wt(5);
   endtask : t_num

   task automatic t_cfg;
      apb(1'b1, OFS_NUM_CFG, 32'h0000_0B04);
      want.gp_in <= 32'h0000_0AB0;
      wt(5);
      apb(1'b0, OFS_NUM_IN, 32'h0000_0000);
      chk("num in", q, 32'h0000_00AB);
      apb(1'b1, OFS_AREA_CFG, 32'h0000_0604);
      apb(1'b1, OFS_REGION, 32'h0000_00FF);
      wt(2);
      chk("area narrow", pout.gp_out, 32'h0000_0070);
      apb(1'b1, OFS_AREA_CFG, AREA_CFG_RST);
      apb(1'b1, OFS_REGION, 32'h0000_00A5);
      wt(2);
      chk("area wide", pout.gp_out, 32'h00A5_0000);
   endtask : t_cfg

   task automatic t_fault;
      apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
      want.hand_fault <= 5'h15;
      want.air_fault  <= 5'h0A;
      wt(5);
      chk("hand", 32'(pout.hand_fault), 32'h0000_0015);
      chk("air", 32'(pout.air_fault), 32'h0000_000A);
      chk("irq on", 32'(irq), 32'h0000_0001);
      apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      chk("irq stat", q & 32'h0000_0006, 32'h0000_0006);
      wt(2);
      chk("irq off", 32'(irq), 32'h0000_0000);
      want.hand_fault <= 5'h00;
      want.air_fault  <= 5'h00;
      wt(5);
      chk("faults off", 32'({pout.hand_fault, pout.air_fault}), 32'h0000_0000);
   endtask : t_fault

   task automatic t_stop;
      for (int p = 0; p < 3; p++) begin
         {want.estop_a_closed, want.estop_b_closed} <= 2'(p);
         wt(5);
         chk("stop", 32'(pout.estop_active), 32'h0000_0001);
         {want.estop_a_closed, want.estop_b_closed} <= 2'h3;
         wt(5);
         chk("stop off", 32'(pout.estop_active), 32'h0000_0000);
      end
   endtask : t_stop

   task automatic t_jog;
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      want.jog_pos    <= 8'h81;
      want.jog_neg    <= 8'h03;
      want.jog_enable <= 1'b1;
      wt(5);
      chk("jog valid", 32'(pout.jog_valid), 32'h0000_0001);
      chk("jog pos", 32'(pout.jog_pos), 32'h0000_0080);
      chk("jog neg", 32'(pout.jog_neg), 32'h0000_0002);
      for (int m = 0; m < 4; m++) begin
         want.jog_mode <= 2'(m);
         wt(5);
         chk("jog mode", 32'(pout.jog_mode), 32'(m));
      end
      want.estop_b_closed <= 1'b0;
      wt(5);
      chk("jog stop", 32'(pout.jog_valid), 32'h0000_0000);
      want.estop_b_closed <= 1'b1;
      want.jog_enable     <= 1'b0;
      wt(5);
      chk("jog pos off", 32'(pout.jog_pos), 32'h0000_0000);
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      want.jog_enable <= 1'b1;
      wt(5);
      chk("jog barred", 32'(pout.jog_valid), 32'h0000_0000);
      apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      chk("irq events", q & 32'h0000_0011, 32'h0000_0011);
   endtask : t_jog

   initial begin
      n_fail  = 0;
      n_tests = 0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      want    = '0;
      want.estop_a_closed = 1'b1;
      want.estop_b_closed = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      wt(6);
      t_regs;
      t_num;
      t_cfg;
      t_fault;
      t_stop;
      t_jog;
      tally_and_finish;
   end

   // Far beyond the few hundred cycles the scenarios need
   initial begin
      #100000;
      n_fail++;
      tally_and_finish;
   end
endmodule : tb_top

`default_nettype wire
